// *** hw/ordr_consts.svh ***
/*
 * Constants of the overrange detect and report block: register addresses,
 * field positions, reset values and counts.
 * Assumes it is included by bare name from the package and the design modules.
 */
// Function
// - Flag refreshed once per output sample.
// - Overrange from analog and digital trip sources.
// - Digital trip when output clips full scale.
// - Nonzero codes map to constant dBFS levels.
// - Threshold mode flags output above threshold.
// - Normal mode flags only full-scale digital trips.
// - Full-overrange mode flags analog or digital trip.
// - Data-valid mode drives low on trip, calibration.
// - Control register selects auto reset, mode, threshold.
// - Auto reset starts converter reset on overrange.
// - Flag held asserted until auto reset completes.
// - Modulator reset after sixteen consecutive analog trips.
// - Analog trips reach flag sample by sample with indication mode set.
// - Data valid on rising clock, inversion bit swaps.
`ifndef ORDR_CONSTS_SVH
`define ORDR_CONSTS_SVH

`define ORDR_ADDR_WIDTH      13
`define ORDR_CTRL_ADDR       13'h0111
`define ORDR_OCLK_ADDR       13'h0016
`define ORDR_CTRL_RESET      8'h00
`define ORDR_OCLK_RESET      8'h00
`define ORDR_AUTO_RESET_ON_OVERRANGE_BIT     7
`define ORDR_INDMODE_BIT     6
`define ORDR_THRESH_MSB      5
`define ORDR_CLKINV_BIT      7
`define ORDR_ANALOG_PERSIST  5'h10
`define ORDR_THRESH_CODES    64

`endif

// *** hw/ordr_pkg.sv ***
/*
 * Types shared by the overrange detect and report modules.
 * Assumes ordr_consts.svh is on the include path.
 */
`include "ordr_consts.svh"

package ordr_pkg;

    // ------------------------------------------------------------------
    // Control register layout
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       autoReset;
        logic       indicationMode;
        logic [5:0] threshold;
    } ordr_ctrl_s;

    typedef enum logic [1:0] {
        ORDR_NORMAL,
        ORDR_THRESHOLD,
        ORDR_FULL_OVERRANGE,
        ORDR_DATA_VALID
    } ordr_mode_e;

    typedef enum logic {
        ORDR_RUN,
        ORDR_SELF_RESET
    } ordr_state_e;

endpackage : ordr_pkg

// *** hw/ordr_threshold_rom.sv ***
/*
 * Constant table of comparison levels, one per threshold code.
 * Assumes the sample is a signed twos complement value of SAMPLE_WIDTH bits.
 */
`timescale 1ns/1ps
`include "ordr_consts.svh"

module ordr_threshold_rom #(
    parameter int SAMPLE_WIDTH = 16
) (
    input  wire logic [5:0]              thresholdCode,
    output logic signed [SAMPLE_WIDTH-1:0] level
);

    // Each nonzero code n stands for n/64 of full scale (code 0 is full scale): code 1 is -36.12 dBFS,
    // code 0x20 is -6.02 dBFS and code 0x3F is -0.14 dBFS.
    logic signed [SAMPLE_WIDTH-1:0] levels [`ORDR_THRESH_CODES];

    generate
        if (SAMPLE_WIDTH < 8) begin : gWidthCheck
            $error("ordr_threshold_rom: SAMPLE_WIDTH must be at least 8");
        end
    endgenerate

    genvar g;
    generate
        for (g = 0; g < `ORDR_THRESH_CODES; g++) begin : gLevel
            if (g == 0) begin : gFull
                assign levels[g] = {1'b0, {(SAMPLE_WIDTH-1){1'b1}}};
            end else begin : gStep
                assign levels[g] = SAMPLE_WIDTH'(g << (SAMPLE_WIDTH - 7));
            end
        end
    endgenerate

    assign level = levels[thresholdCode];

endmodule : ordr_threshold_rom

// *** hw/ordr_top.sv ***
/*
 * Overrange detection and reporting: combines the modulator analog trip with
 * the digital trip of the output engine and drives one overrange flag and
 * the data clock output, both from flip-flops.
 * Assumes sampleStrobe is a one-cycle enable at the output data rate with at
 * least two clocks between strobes, and that configuration writes arrive
 * from the serial control port on the same clock.
 */
`timescale 1ns/1ps
`include "ordr_consts.svh"

module ordr_top #(
    parameter int SAMPLE_WIDTH = 16
) (
    input  wire logic                          ref_clk,
    input  wire logic                          rstn,
    input  wire logic                          sampleStrobe,
    input  wire logic signed [SAMPLE_WIDTH-1:0] sampleData,
    input  wire logic                          engineClip,
    input  wire logic                          analogTrip,
    input  wire logic                          calibrating,
    input  wire logic                          converterResetDone,
    input  wire logic                          cfgWrite,
    input  wire logic                          cfgRead,
    input  wire logic [`ORDR_ADDR_WIDTH-1:0]   cfgAddr,
    input  wire logic [7:0]                    cfgWrData,
    output logic [7:0]                         cfgRdData,
    output logic                               overrangeFlag,
    output logic                               dataClockOut,
    output logic                               converterResetReq,
    output logic                               modulatorResetReq
);

    generate
        if (SAMPLE_WIDTH < 8) begin : gWidthCheck
            $error("ordr_top: SAMPLE_WIDTH must be at least 8");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Analog trip synchroniser
    // ------------------------------------------------------------------
    // The trip comes from the modulator clock domain, so it is retimed
    // before anything looks at it.
    logic tripMeta;
    logic tripSync;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            tripMeta <= 1'b0;
            tripSync <= 1'b0;
        end else begin
            tripMeta <= analogTrip;
            tripSync <= tripMeta;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    localparam logic [7:0] OCLK_RESET = `ORDR_OCLK_RESET;

    ordr_pkg::ordr_ctrl_s ctrl;
    ordr_pkg::ordr_ctrl_s next_ctrl;
    logic                 clkInvert;
    logic                 next_clkInvert;
    logic [7:0]           next_cfgRdData;

    always_comb begin
        next_ctrl      = ctrl;
        next_clkInvert = clkInvert;
        next_cfgRdData = cfgRdData;
        if (cfgWrite && cfgAddr == `ORDR_CTRL_ADDR) begin
            next_ctrl = ordr_pkg::ordr_ctrl_s'(cfgWrData);
        end
        if (cfgWrite && cfgAddr == `ORDR_OCLK_ADDR) begin
            next_clkInvert = cfgWrData[`ORDR_CLKINV_BIT];
        end
        if (cfgRead) begin
            unique case (cfgAddr)
                `ORDR_CTRL_ADDR: next_cfgRdData = 8'(ctrl);
                `ORDR_OCLK_ADDR: next_cfgRdData = {clkInvert, 7'h00};
                default:         next_cfgRdData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl      <= ordr_pkg::ordr_ctrl_s'(`ORDR_CTRL_RESET);
            clkInvert <= OCLK_RESET[`ORDR_CLKINV_BIT];
            cfgRdData <= 8'h00;
        end else begin
            ctrl      <= next_ctrl;
            clkInvert <= next_clkInvert;
            cfgRdData <= next_cfgRdData;
        end
    end

    // ------------------------------------------------------------------
    // Mode decode and trip detection
    // ------------------------------------------------------------------
    ordr_pkg::ordr_mode_e           mode;
    logic signed [SAMPLE_WIDTH-1:0] level;
    logic                           digitalTrip;
    logic                           anyTrip;
    logic [5:0]                     activeCode;

    // With the indication mode set the low threshold bits are don't care,
    // so the digital trip falls back to the full-scale level there.
    assign activeCode = ctrl.indicationMode ? 6'h00 : ctrl.threshold;

    ordr_threshold_rom #(
        .SAMPLE_WIDTH (SAMPLE_WIDTH)
    ) uLevels (
        .thresholdCode (activeCode),
        .level         (level)
    );

    always_comb begin
        if (!ctrl.indicationMode) begin
            mode = (ctrl.threshold == 6'h00) ? ordr_pkg::ORDR_NORMAL
                                             : ordr_pkg::ORDR_THRESHOLD;
        end else begin
            mode = ctrl.threshold[`ORDR_THRESH_MSB] ? ordr_pkg::ORDR_DATA_VALID
                                                    : ordr_pkg::ORDR_FULL_OVERRANGE;
        end
    end

    // The sample is taken before output formatting, so the signed compare
    // holds for every output format.
    assign digitalTrip = engineClip || (sampleData > level);
    assign anyTrip     = tripSync || digitalTrip;

    // ------------------------------------------------------------------
    // Analog persistence counter
    // ------------------------------------------------------------------
    logic [4:0] persistCount;
    logic [4:0] next_persistCount;
    logic       next_modulatorResetReq;

    always_comb begin
        next_persistCount      = tripSync ? persistCount : 5'h00;
        next_modulatorResetReq = 1'b0;
        if (tripSync && persistCount != `ORDR_ANALOG_PERSIST) begin
            next_persistCount = persistCount + 5'h01;
        end
        if (tripSync && ctrl.autoReset
            && persistCount == `ORDR_ANALOG_PERSIST - 5'h01) begin
            next_modulatorResetReq = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            persistCount      <= 5'h00;
            modulatorResetReq <= 1'b0;
        end else begin
            persistCount      <= next_persistCount;
            modulatorResetReq <= next_modulatorResetReq;
        end
    end

    // ------------------------------------------------------------------
    // Automatic self reset
    // ------------------------------------------------------------------
    ordr_pkg::ordr_state_e state;
    ordr_pkg::ordr_state_e next_state;
    logic                  next_converterResetReq;
    logic                  detected;

    always_comb begin
        unique case (mode)
            ordr_pkg::ORDR_NORMAL,
            ordr_pkg::ORDR_THRESHOLD: detected = digitalTrip;
            ordr_pkg::ORDR_FULL_OVERRANGE,
            ordr_pkg::ORDR_DATA_VALID: detected = anyTrip;
        endcase
    end

    always_comb begin
        next_state             = state;
        next_converterResetReq = converterResetReq;
        unique case (state)
            ordr_pkg::ORDR_RUN: begin
                if (ctrl.autoReset && sampleStrobe && detected) begin
                    next_state             = ordr_pkg::ORDR_SELF_RESET;
                    next_converterResetReq = 1'b1;
                end
            end
            ordr_pkg::ORDR_SELF_RESET: begin
                if (converterResetDone) begin
                    next_state             = ordr_pkg::ORDR_RUN;
                    next_converterResetReq = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state             <= ordr_pkg::ORDR_RUN;
            converterResetReq <= 1'b0;
        end else begin
            state             <= next_state;
            converterResetReq <= next_converterResetReq;
        end
    end

    // ------------------------------------------------------------------
    // Flag and data clock output
    // ------------------------------------------------------------------
    // The flag changes on the strobe, together with the falling phase of
    // the data clock (the rising phase with the inversion bit set), so it is stable around the opposite edge.
    logic flagActive;
    logic next_overrangeFlag;
    logic next_dataClockOut;

    assign flagActive = detected || (mode == ordr_pkg::ORDR_DATA_VALID && calibrating)
                        || next_state == ordr_pkg::ORDR_SELF_RESET;

    always_comb begin
        next_overrangeFlag = overrangeFlag;
        next_dataClockOut  = ~clkInvert;
        if (sampleStrobe) begin
            next_dataClockOut = clkInvert;
            unique case (mode)
                ordr_pkg::ORDR_DATA_VALID: next_overrangeFlag = ~flagActive;
                default:                   next_overrangeFlag = flagActive;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            overrangeFlag <= 1'b0;
            dataClockOut  <= 1'b0;
        end else begin
            overrangeFlag <= next_overrangeFlag;
            dataClockOut  <= next_dataClockOut;
        end
    end

endmodule : ordr_top

// *** test/ordr_receiver.sv ***
/* Receiving logic model: latches the overrange flag on the data clock output.
 * Assumes both signals come straight from the block's flip-flops. */
`timescale 1ns/1ps
module ordr_receiver (
    input  wire logic dataClockOut,
    input  wire logic overrangeFlag,
    output logic      capturedFlag
);
    // With the clock inversion bit set, the falling edge gives the widest setup and hold margin around the update.
    always_ff @(negedge dataClockOut) capturedFlag <= overrangeFlag;
endmodule : ordr_receiver

// *** test/ordr_checker_assertions.sv ***
/* Concurrent checks on the ports of ordr_top, bound below.
 * Assumes register writes act on the cycle after the write strobe. */
`timescale 1ns/1ps
`include "ordr_consts.svh"
module ordr_assertions #(
    parameter int SAMPLE_WIDTH = 16
) (
    input wire logic                           ref_clk,
    input wire logic                           rstn,
    input wire logic                           sampleStrobe,
    input wire logic signed [SAMPLE_WIDTH-1:0] sampleData,
    input wire logic                           engineClip,
    input wire logic                           analogTrip,
    input wire logic                           calibrating,
    input wire logic                           converterResetDone,
    input wire logic                           cfgWrite,
    input wire logic                           cfgRead,
    input wire logic [`ORDR_ADDR_WIDTH-1:0]    cfgAddr,
    input wire logic [7:0]                     cfgWrData,
    input wire logic [7:0]                     cfgRdData,
    input wire logic                           overrangeFlag,
    input wire logic                           dataClockOut,
    input wire logic                           converterResetReq,
    input wire logic                           modulatorResetReq
);
    // --------------------------------------------
    // Shadow of the control registers
    // --------------------------------------------
    logic [7:0] ctrl, next_ctrl;
    logic       clkInv, next_clkInv;
    logic [4:0] tripRun, next_tripRun;
    logic       tripD1, tripD2;
    logic       dig;
    int         lvl;
    assign lvl = (ctrl[6] || ctrl[5:0] == 6'h00) ? 32767 : int'(ctrl[5:0]) * 512;
    assign dig = engineClip || (int'(sampleData) > lvl);
    always_comb begin
        next_ctrl = (cfgWrite && cfgAddr == `ORDR_CTRL_ADDR) ? cfgWrData : ctrl;
        next_clkInv = (cfgWrite && cfgAddr == `ORDR_OCLK_ADDR) ? cfgWrData[7] : clkInv;
        next_tripRun = !tripD2 ? 5'h00 : (tripRun == 5'h1f ? tripRun : tripRun + 5'h01);
    end
    always_ff @(posedge ref_clk) begin
        ctrl <= rstn ? next_ctrl : `ORDR_CTRL_RESET;
        clkInv <= rstn ? next_clkInv : 1'b0;
        tripRun <= rstn ? next_tripRun : 5'h00;
        // The trip pin is retimed by two flops inside the block; mirror that.
        tripD1 <= rstn ? analogTrip : 1'b0;
        tripD2 <= rstn ? tripD1 : 1'b0;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence s_trip_held;
        analogTrip [*3];
    endsequence
    sequence s_trip_clear;
        !analogTrip [*3];
    endsequence
    a_flag_on_strobe: assert property ($past(rstn) && $changed(overrangeFlag) |-> $past(sampleStrobe))
        else $error("flag moved between samples");
    a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> !overrangeFlag && !converterResetReq)
        else $error("outputs active in reset");
    a_digital_trip: assert property (sampleStrobe && !ctrl[6] && !converterResetReq |=> overrangeFlag == $past(dig))
        else $error("digital trip flag wrong");
    a_full_trip: assert property (s_trip_held ##0 (sampleStrobe && ctrl[6:5] == 2'b10) |=> overrangeFlag)
        else $error("analog trip not flagged");
    a_valid_low: assert property (sampleStrobe && ctrl[6:5] == 2'b11 && calibrating |=> !overrangeFlag)
        else $error("valid flag high in calibration");
    a_valid_high: assert property (s_trip_clear ##0 (sampleStrobe && ctrl[6:5] == 2'b11 && !calibrating
        && !dig && !converterResetReq) |=> overrangeFlag)
        else $error("valid flag low without trip");
    a_enter_reset: assert property (sampleStrobe && ctrl[7] && !ctrl[6] && dig |=> converterResetReq)
        else $error("self reset not started");
    a_reset_done: assert property (converterResetReq && converterResetDone |=> !converterResetReq)
        else $error("self reset not ended");
    a_mod_persist: assert property (modulatorResetReq |-> tripRun == 5'd16)
        else $error("modulator reset too early");
    a_mod_fires: assert property (ctrl[7] && tripD2 && tripRun == 5'd15 |=> modulatorResetReq)
        else $error("modulator reset missing");
    a_clock_out: assert property (sampleStrobe |=> dataClockOut == clkInv ##1 dataClockOut == !clkInv)
        else $error("data clock phase wrong");
    a_read_back: assert property (cfgRead && cfgAddr == `ORDR_CTRL_ADDR
        |=> cfgRdData == $past(ctrl))
        else $error("control readback wrong");
endmodule : ordr_assertions
bind ordr_top ordr_assertions #(.SAMPLE_WIDTH(SAMPLE_WIDTH)) i_ordr_assertions (.ref_clk, .rstn,
    .sampleStrobe, .sampleData, .engineClip, .analogTrip, .calibrating, .converterResetDone,
    .cfgWrite, .cfgRead, .cfgAddr, .cfgWrData, .cfgRdData, .overrangeFlag, .dataClockOut,
    .converterResetReq, .modulatorResetReq);

// *** test/testbench.sv ***
/* Self-checking bench for ordr_top with a falling-edge receiver model.
 * Assumes the design and checker files are compiled first. */
`timescale 1ns/1ps
`include "ordr_consts.svh"
module testbench;
    logic ref_clk = 0, rstn = 0, sampleStrobe = 0, engineClip = 0, analogTrip = 0;
    logic calibrating = 0, converterResetDone = 0, cfgWrite = 0, cfgRead = 0;
    logic overrangeFlag, dataClockOut, converterResetReq, modulatorResetReq, capturedFlag;
    logic signed [15:0]              sampleData = 0;
    logic [`ORDR_ADDR_WIDTH-1:0]     cfgAddr = 0;
    logic [7:0]                      cfgWrData = 0, cfgRdData;
    logic [15:0]                     d;
    logic [5:0]                      code;
    logic                            expQ[$];
    int                              n_errors = 0, tests_run = 0, i;
    localparam logic [12:0] CTRL = `ORDR_CTRL_ADDR;
    ordr_top i_ordr_top (.ref_clk, .rstn, .sampleStrobe, .sampleData, .engineClip, .analogTrip,
        .calibrating, .converterResetDone, .cfgWrite, .cfgRead, .cfgAddr, .cfgWrData, .cfgRdData,
        .overrangeFlag, .dataClockOut, .converterResetReq, .modulatorResetReq);
    ordr_receiver i_ordr_receiver (.dataClockOut, .overrangeFlag, .capturedFlag);
    initial forever #25 ref_clk = ~ref_clk;
    // ----------------------------------
    // Bus and sample tasks
    // ----------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [12:0] a, input logic [7:0] v);
        cfgAddr = a;
        cfgWrData = v;
        cfgWrite = 1'b1;
        cyc(1);
        cfgWrite = 1'b0;
        cyc(1);
    endtask : wr
    task automatic rd(input logic [12:0] a, input logic [7:0] e);
        cfgAddr = a;
        cfgRead = 1'b1;
        cyc(1);
        cfgRead = 1'b0;
        cyc(1);
        check("readData", {8'h00, cfgRdData}, {8'h00, e});
    endtask : rd
    // Strobes stay three cycles apart, which leaves the two clocks between strobes that the block needs.
    task automatic smp(input logic [15:0] v, input logic c, input logic e);
        sampleData = v;
        engineClip = c;
        sampleStrobe = 1'b1;
        expQ.push_back(e);
        cyc(1);
        sampleStrobe = 1'b0;
        cyc(2);
    endtask : smp
    initial forever begin
        @(posedge ref_clk);
        if (sampleStrobe === 1'b1) begin
            @(posedge ref_clk);
            #2;
            check("flag", overrangeFlag, expQ.pop_front());
        end
    end
    task automatic end_sim;
        if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    initial begin
        #(50 * 5000);
        n_errors++;
        end_sim;
    end
    initial begin
        void'($urandom(32'h566dce67));
        cyc(20);
        rstn = 1'b1;
        cyc(1);
        rd(CTRL, 8'h00);
        wr(CTRL, 8'h20);
        rd(CTRL, 8'h20);
        rd(13'h0005, 8'h00);
        smp(16'h4001, 0, 1);
        smp(16'h4000, 0, 0);
        smp(16'hc000, 0, 0);
        for (i = 0; i < 20; i++) begin
            code = 6'($urandom_range(1, 63));
            d = 16'($urandom);
            wr(CTRL, {2'b00, code});
            smp(d, 0, int'($signed(d)) > int'(code) * 512);
        end
        wr(CTRL, 8'h00);
        smp(16'h7fff, 0, 0);
        smp(16'h7fff, 1, 1);
        wr(CTRL, 8'h80);
        smp(16'h7fff, 1, 1);
        check("selfReset", converterResetReq, 1);
        smp(16'h0000, 0, 1);
        converterResetDone = 1'b1;
        cyc(1);
        converterResetDone = 1'b0;
        cyc(1);
        check("selfReset", converterResetReq, 0);
        wr(CTRL, 8'h5f);
        smp(16'h7000, 0, 0);
        analogTrip = 1'b1;
        cyc(3);
        smp(16'h0000, 0, 1);
        analogTrip = 1'b0;
        wr(CTRL, 8'h60);
        smp(16'h0000, 0, 1);
        calibrating = 1'b1;
        smp(16'h0000, 0, 0);
        calibrating = 1'b0;
        smp(16'h0000, 1, 0);
        wr(`ORDR_OCLK_ADDR, 8'h80);
        rd(`ORDR_OCLK_ADDR, 8'h80);
        smp(16'h0000, 0, 1);
        check("captured", capturedFlag, 1);
        smp(16'h0000, 1, 0);
        check("captured", capturedFlag, 0);
        wr(CTRL, 8'hc0);
        analogTrip = 1'b1;
        cyc(3);
        smp(16'h0000, 0, 1);
        check("selfReset", converterResetReq, 1);
        for (i = 0; i < 40 && modulatorResetReq !== 1'b1; i++) cyc(1);
        check("modReset", modulatorResetReq, 1);
        analogTrip = 1'b0;
        cyc(3);
        smp(16'h0000, 0, 1);
        converterResetDone = 1'b1;
        cyc(1);
        converterResetDone = 1'b0;
        cyc(1);
        check("selfReset", converterResetReq, 0);
        wr(CTRL, 8'h60);
        smp(16'h0000, 0, 1);
        rstn = 1'b0;
        cyc(2);
        check("resetFlag", overrangeFlag, 0);
        rstn = 1'b1;
        cyc(1);
        rd(CTRL, 8'h00);
        end_sim;
    end
endmodule : testbench
